// ---- rtl/plbs_defs.svh ----
`ifndef PLBS_DEFS_SVH
`define PLBS_DEFS_SVH
// ============================================================
// register offsets (word index on the plain register port)
`define OFF_CTRL        3'h0
`define OFF_BLK_SEL     3'h1
`define OFF_BLK_RAW     3'h2
`define OFF_RATIO_SEL   3'h3
`define OFF_RATIO_VAL   3'h4
`define OFF_SHIFT       3'h5
`define OFF_STATUS      3'h6
// ============================================================
// field positions
`define CTRL_DEPTH12_BIT  0
`define CTRL_VARIANT_LSB  1
`define STAT_FRAME_BIT    0
`define STAT_PEND_BIT     1
`define STAT_SAT_BIT      2
// ============================================================
// reset values and limits
`define RST_CTRL        3'h0
`define RST_BLK         10'h000
`define RST_SHIFT       3'h0
`define RATIO_UNITY     10'h040
`define RATIO_MAX       10'h3FF
`define BLK_SEL_ALL     2'h0
`define BLK_MAX_STD     10'h0FF
`define BLK_MAX_NOSH    10'h040
`define BLK_MAX_WIDE    10'h3FF
`define SHIFT_MAX       3'h4
`define PIX_MAX12       12'hFFF
`define PIX_MAX8        12'h0FF
`endif

// ---- rtl/plbs_pkg.sv ----
`default_nettype none
package plbs_pkg;
    // model variant: standard, no-shift, high-res, high-res wide range
    typedef enum logic [1:0] {
        VAR_STD  = 2'h0,
        VAR_NOSH = 2'h1,
        VAR_HIRS = 2'h2,
        VAR_WIDE = 2'h3
    } variant_e;
    // colour of a pixel, also the ratio selector code
    typedef enum logic [1:0] {
        COL_RED   = 2'h0,
        COL_GREEN = 2'h1,
        COL_BLUE  = 2'h2
    } colour_e;
    // frame tracker
    typedef enum logic [1:0] {
        FR_IDLE = 2'h1,
        FR_BUSY = 2'h2
    } frame_e;
    // one pixel beat on the stream
    typedef struct packed {
        logic        valid;
        logic        sof;
        logic        eof;
        logic [1:0]  colour;
        logic [11:0] data;
    } pix_s;
endpackage : plbs_pkg
`default_nettype wire

// ---- rtl/balance_ratio_mem.sv ----
`include "plbs_defs.svh"
`default_nettype none
module balance_ratio_mem (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    // software side, shadow copy
    input  wire logic       wr_en_in,
    input  wire logic [1:0] wr_idx_in,
    input  wire logic [9:0] wr_data_in,
    input  wire logic       commit_in,
    input  wire logic [1:0] sh_idx_in,
    output logic      [9:0] sh_data_out,
    // pixel side, active copy
    input  wire logic [1:0] rd_idx_in,
    output logic      [9:0] rd_data_out
);
    logic [9:0] shadow_ff [3];
    logic [9:0] active_ff [3];

    // ============================================================
    // storage: one shadow and one active ratio per colour
    for (genvar i = 0; i < 3; i++) begin : g_ent
        always_ff @(posedge clk_sys_in) begin
            if (!rst_b_in) begin
                shadow_ff[i] <= `RATIO_UNITY;
                active_ff[i] <= `RATIO_UNITY;
            end else begin
                if (wr_en_in && wr_idx_in == 2'(i))
                    shadow_ff[i] <= wr_data_in;
                if (commit_in)
                    active_ff[i] <= shadow_ff[i];
            end
        end
    end

    // ============================================================
    // registered reads; commit bypass so the first pixel of a
    // frame already sees the new ratio; index 3 reads unity
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rd_data_out <= `RATIO_UNITY;
            sh_data_out <= `RATIO_UNITY;
        end else begin
            if (rd_idx_in == 2'h3)
                rd_data_out <= `RATIO_UNITY;
            else if (commit_in)
                rd_data_out <= shadow_ff[rd_idx_in];
            else
                rd_data_out <= active_ff[rd_idx_in];
            sh_data_out <= (sh_idx_in == 2'h3) ? `RATIO_UNITY
                                               : shadow_ff[sh_idx_in];
        end
    end
endmodule : balance_ratio_mem
`default_nettype wire

// ---- rtl/pixel_level_balance_shift.sv ----
// Chosen here: the strobed register port and the address map.
`include "plbs_defs.svh"
// Operation
// R1: standard 8 bit: one count per 16
// R2: standard 12 bit: one count per one
// R3: no-shift variant: one count per 4
// R4: high-res 8 bit: one count per 64
// R5: high-res 12 bit: one count per 4
// R6: black range 255, 64 or 1023
// R7: host selects all-channels before black write
// R8: each colour scaled by own ratio
// R9: ratio range 0.00 to 15.9844
// R10: host selects colour, then writes its ratio
// R11: no shift on no-shift variant; x2..x16
// R12: 12 bit no shift passes bits unchanged
// R13: 12 bit shift one: bits 10..0, zero
// R14: 12 bit shift two: bits 9..0, zeros
// R15: 12 bit shift three: bits 8..0, zeros
// R16: any bit above window saturates output
// R17: host keeps readings low enough to shift
// R18: 12 bit shift four: bits 7..0, zeros
// R19: 8 bit no shift outputs bits 11..4
// R20: shift code 0 off, 1..4 shift amount
// R21: clamp after offset and scaling
// R22: settings change only at frame start
`default_nettype none
module pixel_level_balance_shift (
    // clock and reset
    input  wire logic           clk_sys_in,
    input  wire logic           rst_b_in,
    // register port
    input  wire logic [2:0]     reg_addr_in,
    input  wire logic [15:0]    reg_wdata_in,
    input  wire logic           reg_wr_in,
    input  wire logic           reg_rd_in,
    output logic      [15:0]    reg_rdata_out,
    // pixel stream
    input  wire plbs_pkg::pix_s pix_in,
    output var  plbs_pkg::pix_s pix_out
);
    // ============================================================
    // decoding helpers
    function automatic logic [9:0] blk_max(input logic [1:0] v);
        unique case (v)
            plbs_pkg::VAR_NOSH: blk_max = `BLK_MAX_NOSH;
            plbs_pkg::VAR_WIDE: blk_max = `BLK_MAX_WIDE;
            default:            blk_max = `BLK_MAX_STD;
        endcase
    endfunction : blk_max

    // offset in 12 bit digitizer counts; coarse steps truncate
    function automatic logic [11:0] blk_offset(input logic [1:0] v,
                                               input logic d12,
                                               input logic [9:0] b);
        logic [11:0] o;
        o = 12'h000;
        unique case (v)
            plbs_pkg::VAR_NOSH:
                o = d12 ? {4'h0, b[9:2]}                  // [R3]
                        : {b[9:2], 4'h0};                 // [R3]
            plbs_pkg::VAR_HIRS, plbs_pkg::VAR_WIDE:
                o = d12 ? {4'h0, b[9:2]}                  // [R5]
                        : {4'h0, b[9:6], 4'h0};           // [R4]
            default:
                o = d12 ? {2'h0, b}                       // [R2]
                        : {2'h0, b[9:4], 4'h0};           // [R1]
        endcase
        blk_offset = o;
    endfunction : blk_offset

    // true when a set bit lies above the selected window
    function automatic logic above_window(input logic [11:0] v,
                                          input logic [2:0] sh);
        above_window = (sh != 3'h0) && ((v >> (4'hC - 4'(sh))) != 12'h0);
    endfunction : above_window

    // ============================================================
    // software shadow settings
    logic [2:0]  ctrl_ff;
    logic [1:0]  blk_sel_ff;
    logic [9:0]  blk_ff;
    logic [1:0]  ratio_sel_ff;
    logic [2:0]  shift_ff;
    logic        pend_ff;
    logic        sat_seen_ff;
    logic [1:0]  var_w;
    logic        wr_ctrl;
    logic        wr_blk;
    logic        wr_ratio;
    logic        wr_shift;
    logic [9:0]  ratio_wval;
    logic        commit;
    logic        sat_evt;

    assign var_w    = ctrl_ff[`CTRL_VARIANT_LSB +: 2];
    assign wr_ctrl  = reg_wr_in && reg_addr_in == `OFF_CTRL;
    assign wr_blk   = reg_wr_in && reg_addr_in == `OFF_BLK_RAW
                      && blk_sel_ff == `BLK_SEL_ALL;          // [R7]
    assign wr_ratio = reg_wr_in && reg_addr_in == `OFF_RATIO_VAL;
    assign wr_shift = reg_wr_in && reg_addr_in == `OFF_SHIFT
                      && reg_wdata_in[15:3] == 13'h0
                      && reg_wdata_in[2:0] <= `SHIFT_MAX;     // [R20]
    // ratio is unsigned 4.6 fixed point; larger values saturate
    assign ratio_wval = (reg_wdata_in[15:10] != 6'h0) ? `RATIO_MAX
                        : reg_wdata_in[9:0];                  // [R9]
    assign commit   = pix_in.valid && pix_in.sof;             // [R22]

    // control word and selectors
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ctrl_ff      <= `RST_CTRL;
            blk_sel_ff   <= `BLK_SEL_ALL;
            ratio_sel_ff <= plbs_pkg::COL_RED;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= reg_wdata_in[2:0];
            if (reg_wr_in && reg_addr_in == `OFF_BLK_SEL)
                blk_sel_ff <= reg_wdata_in[1:0];
            if (reg_wr_in && reg_addr_in == `OFF_RATIO_SEL)
                ratio_sel_ff <= reg_wdata_in[1:0];            // [R10]
        end
    end

    // black level, clamped to the variant range; a variant change
    // re-clamps the stored value on the cycle after the change
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            blk_ff <= `RST_BLK;
        else if (wr_blk)
            blk_ff <= (reg_wdata_in > 16'(blk_max(var_w)))
                      ? blk_max(var_w) : reg_wdata_in[9:0];   // [R6]
        else if (blk_ff > blk_max(var_w))
            blk_ff <= blk_max(var_w);                         // [R6]
    end

    // shift code; the no-shift variant holds it at zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            shift_ff <= `RST_SHIFT;
        else if (var_w == plbs_pkg::VAR_NOSH)
            shift_ff <= `RST_SHIFT;                           // [R11]
        else if (wr_shift)
            shift_ff <= reg_wdata_in[2:0];                    // [R20]
    end

    // pending flag: a write in the commit cycle stays pending
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            pend_ff <= 1'b0;
        else if (wr_ctrl || wr_blk || wr_ratio || wr_shift)
            pend_ff <= 1'b1;
        else if (commit)
            pend_ff <= 1'b0;
    end

    // sticky saturation flag, write one to clear, set wins
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            sat_seen_ff <= 1'b0;
        else if (sat_evt)
            sat_seen_ff <= 1'b1;
        else if (reg_wr_in && reg_addr_in == `OFF_STATUS
                 && reg_wdata_in[`STAT_SAT_BIT])
            sat_seen_ff <= 1'b0;
    end

    // ============================================================
    // active settings, loaded only with the first pixel of a frame
    logic        act_d12_ff;
    logic [1:0]  act_var_ff;
    logic [9:0]  act_blk_ff;
    logic [2:0]  act_shift_ff;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            act_d12_ff   <= 1'b0;
            act_var_ff   <= plbs_pkg::VAR_STD;
            act_blk_ff   <= `RST_BLK;
            act_shift_ff <= `RST_SHIFT;
        end else if (commit) begin                            // [R22]
            act_d12_ff   <= ctrl_ff[`CTRL_DEPTH12_BIT];
            act_var_ff   <= var_w;
            act_blk_ff   <= blk_ff;
            act_shift_ff <= shift_ff;
        end
    end

    // frame tracker, shown in status
    plbs_pkg::frame_e fr_ff;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            fr_ff <= plbs_pkg::FR_IDLE;
        else if (pix_in.valid) begin
            unique case (fr_ff)
                plbs_pkg::FR_IDLE:
                    if (pix_in.sof && !pix_in.eof)
                        fr_ff <= plbs_pkg::FR_BUSY;
                plbs_pkg::FR_BUSY:
                    if (pix_in.eof)
                        fr_ff <= plbs_pkg::FR_IDLE;
                default:
                    fr_ff <= plbs_pkg::FR_IDLE;
            endcase
        end
    end

    // ============================================================
    // ratio store: shadow written by software, active per frame
    logic [9:0] ratio_px;
    logic [9:0] ratio_sh;

    balance_ratio_mem u_ratio (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (wr_ratio),
        .wr_idx_in   (ratio_sel_ff),                          // [R10]
        .wr_data_in  (ratio_wval),
        .commit_in   (commit),
        .sh_idx_in   (ratio_sel_ff),
        .sh_data_out (ratio_sh),
        .rd_idx_in   (pix_in.colour),                         // [R8]
        .rd_data_out (ratio_px)
    );

    // ============================================================
    // stage one: capture the pixel beside its ratio read
    plbs_pkg::pix_s p1_ff;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            p1_ff <= '0;
        else
            p1_ff <= pix_in;
    end

    // stage two arithmetic: offset, scale, clamp, window
    logic [12:0] sum;
    logic [22:0] prod;
    logic [16:0] scaled;
    logic [11:0] clamped;
    logic [11:0] win;
    logic        sat;
    logic [11:0] nxt_data;

    always_comb begin
        sum     = {1'b0, p1_ff.data}
                  + {1'b0, blk_offset(act_var_ff, act_d12_ff, act_blk_ff)};
        prod    = 23'(sum) * 23'(ratio_px);                   // [R8]
        scaled  = prod[22:6];
        clamped = (scaled[16:12] != 5'h0) ? `PIX_MAX12
                                          : scaled[11:0];     // [R21]
        win     = 12'(clamped << act_shift_ff); // [R13][R14][R15][R18]
        sat     = above_window(clamped, act_shift_ff);        // [R16]
        if (act_d12_ff)
            nxt_data = sat ? `PIX_MAX12 : win;                // [R12]
        else
            nxt_data = sat ? `PIX_MAX8 : {4'h0, win[11:4]};   // [R19]
    end

    assign sat_evt = p1_ff.valid && sat;

    // output register; two cycles from input to output
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in)
            pix_out <= '0;
        else begin
            pix_out      <= p1_ff;
            pix_out.data <= p1_ff.valid ? nxt_data : 12'h000;
        end
    end

    // ============================================================
    // register reads; ratio comes straight from the store's
    // registered port so a read right after a write is current
    logic [15:0] rdata_ff;
    logic        rd_ratio_ff;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_ff    <= 16'h0000;
            rd_ratio_ff <= 1'b0;
        end else begin
            rd_ratio_ff <= reg_rd_in && reg_addr_in == `OFF_RATIO_VAL;
            rdata_ff    <= 16'h0000;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    `OFF_CTRL:      rdata_ff <= {13'h0, ctrl_ff};
                    `OFF_BLK_SEL:   rdata_ff <= {14'h0, blk_sel_ff};
                    `OFF_BLK_RAW:   rdata_ff <= {6'h0, blk_ff};
                    `OFF_RATIO_SEL: rdata_ff <= {14'h0, ratio_sel_ff};
                    `OFF_SHIFT:     rdata_ff <= {13'h0, shift_ff};
                    `OFF_STATUS:    rdata_ff <= {13'h0, sat_seen_ff,
                                       pend_ff, fr_ff == plbs_pkg::FR_BUSY};
                    default:        rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata_out = rd_ratio_ff ? {6'h0, ratio_sh} : rdata_ff;

    // ============================================================
    // checks
    logic unity;
    assign unity = ratio_px == `RATIO_UNITY && act_blk_ff == 10'h0;

    chk_pixel_latency: assert property (@(posedge clk_sys_in) // [R8]
        disable iff (!rst_b_in) pix_in.valid |-> ##2 pix_out.valid)
        else $error("pixel did not leave two cycles later");
    chk_pass_twelve: assert property (@(posedge clk_sys_in) // [R12]
        disable iff (!rst_b_in) p1_ff.valid && act_d12_ff && unity
        && act_shift_ff == 3'h0 |=> pix_out.data == $past(p1_ff.data))
        else $error("12 bit unshifted pixel altered");
    chk_shift_one: assert property (@(posedge clk_sys_in) // [R13]
        disable iff (!rst_b_in) p1_ff.valid && act_d12_ff && unity
        && act_shift_ff == 3'h1 && !p1_ff.data[11]
        |=> pix_out.data == {$past(p1_ff.data[10:0]), 1'b0})
        else $error("shift by one window wrong");
    chk_shift_four: assert property (@(posedge clk_sys_in) // [R18]
        disable iff (!rst_b_in) p1_ff.valid && act_d12_ff && unity
        && act_shift_ff == 3'h4 && p1_ff.data[11:8] == 4'h0
        |=> pix_out.data == {$past(p1_ff.data[7:0]), 4'h0})
        else $error("shift by four window wrong");
    chk_eight_drop: assert property (@(posedge clk_sys_in) // [R19]
        disable iff (!rst_b_in) p1_ff.valid && !act_d12_ff && unity
        && act_shift_ff == 3'h0
        |=> pix_out.data == {4'h0, $past(p1_ff.data[11:4])})
        else $error("8 bit pixel not bits 11 to 4");
    chk_sat_window: assert property (@(posedge clk_sys_in) // [R16]
        disable iff (!rst_b_in) p1_ff.valid && unity && act_shift_ff != 0
        && above_window(p1_ff.data, act_shift_ff) |=> pix_out.data ==
        ($past(act_d12_ff) ? `PIX_MAX12 : `PIX_MAX8))
        else $error("overflowing pixel not saturated");
    chk_commit_frame: assert property (@(posedge clk_sys_in) // [R22]
        disable iff (!rst_b_in) !commit |=> $stable(act_shift_ff)
        && $stable(act_blk_ff) && $stable(act_d12_ff))
        else $error("setting changed inside a frame");
    chk_black_range: assert property (@(posedge clk_sys_in) // [R6]
        disable iff (!rst_b_in) wr_blk ##1 !wr_ctrl |=>
        blk_ff <= blk_max(var_w))
        else $error("black level out of range");
    chk_noshift_var: assert property (@(posedge clk_sys_in) // [R11]
        disable iff (!rst_b_in) var_w == plbs_pkg::VAR_NOSH
        && !wr_ctrl |=> shift_ff == 3'h0)
        else $error("shift active on no-shift variant");
endmodule : pixel_level_balance_shift
`default_nettype wire

// ---- verification/sensor_adc_model.sv ----
`default_nettype none
module sensor_adc_model (
    // clock and reset
    input  wire logic           clk_sys_in,
    input  wire logic           rst_b_in,
    // bench request
    input  wire logic           send_in,
    input  wire plbs_pkg::pix_s beat_in,
    // digitizer stream
    output var  plbs_pkg::pix_s pix_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // beat launch
    // idle cycles carry inverted colour and data, so a stale word
    // can never pass for a fresh pixel
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pix_out <= '0;
        end else if (send_in) begin
            pix_out       <= beat_in;
            pix_out.valid <= 1'b1;
        end else begin
            pix_out <= {3'h0, ~pix_out.colour, ~pix_out.data};
        end
    end
endmodule : sensor_adc_model
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // signals
    typedef struct packed {
        logic [2:0]       ctrl;
        logic [9:0]       blk;
        logic [2:0]       sh;
        logic [2:0][9:0]  rat;
    } cfg_s;
    logic           clk_sys_in;
    logic           rst_b_in;
    logic [2:0]     reg_addr_in;
    logic [15:0]    reg_wdata_in;
    logic           reg_wr_in;
    logic           reg_rd_in;
    logic [15:0]    reg_rdata_out;
    plbs_pkg::pix_s pix_in;
    plbs_pkg::pix_s pix_out;
    logic           send;
    plbs_pkg::pix_s beat;
    cfg_s           sh_m;
    cfg_s           act_m;
    logic [1:0]     bsel_m;
    logic [1:0]     rsel_m;
    logic [15:0]    exp_q[$];
    int             miscompares;
    int             n_compared;
    int             cycles;
    // ============================================================
    // design and digitizer model
    pixel_level_balance_shift pixel_level_balance_shift_inst (
        .clk_sys_in   (clk_sys_in),
        .rst_b_in     (rst_b_in),
        .reg_addr_in  (reg_addr_in),
        .reg_wdata_in (reg_wdata_in),
        .reg_wr_in    (reg_wr_in),
        .reg_rd_in    (reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .pix_in       (pix_in),
        .pix_out      (pix_out)
    );
    sensor_adc_model sensor_adc_model_inst (
        .clk_sys_in(clk_sys_in),
        .rst_b_in  (rst_b_in),
        .send_in   (send),
        .beat_in   (beat),
        .pix_out   (pix_in)
    );
    // 10 MHz clock
    always #50 clk_sys_in = ~clk_sys_in;
    // ============================================================
    // expectations
    function automatic logic [9:0] blk_max(input logic [1:0] v);
        case (v)
            2'h1: return 10'h040;
            2'h3: return 10'h3FF;
            default: return 10'h0FF;
        endcase
    endfunction : blk_max
    // offset is added before scaling, so the ratio scales it too
    function automatic logic [11:0] exp_pix(input cfg_s c,
                                            input logic [1:0] col,
                                            input logic [11:0] d);
        int off;
        int v;
        int s;
        if (c.ctrl[2:1] == 2'h0) off = c.ctrl[0] ? c.blk : c.blk / 16 * 16;
        else if (c.ctrl[2:1] == 2'h1)
            off = c.ctrl[0] ? c.blk / 4 : c.blk / 4 * 16;
        else off = c.ctrl[0] ? c.blk / 4 : c.blk / 64 * 16;
        v = (int'(d) + off) * ((col == 2'h3) ? 64 : int'(c.rat[col])) >> 6;
        if (v > 4095) v = 4095;
        s = (c.ctrl[2:1] == 2'h1) ? 0 : int'(c.sh);
        if (s > 0 && (v >> (12 - s)) != 0)
            return c.ctrl[0] ? 12'hFFF : 12'h0FF;
        v = (v << s) & 4095;
        return c.ctrl[0] ? 12'(v) : 12'(v >> 4);
    endfunction : exp_pix
    function automatic logic [15:0] exp_reg(input logic [2:0] a);
        case (a)
            3'h0: return {13'h0, sh_m.ctrl};
            3'h1: return {14'h0, bsel_m};
            3'h2: return {6'h0, sh_m.blk};
            3'h3: return {14'h0, rsel_m};
            3'h4: return {6'h0, sh_m.rat[rsel_m]};
            3'h5: return {13'h0, sh_m.sh};
            default: return 16'h0000;
        endcase
    endfunction : exp_reg
    // ============================================================
    // checking and closing
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : check
    task automatic results();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // ============================================================
    // register port tasks; the mirror follows the refusal rules
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        case (a)
            3'h0: begin
                sh_m.ctrl = d[2:0];
                if (sh_m.blk > blk_max(d[2:1])) sh_m.blk = blk_max(d[2:1]);
            end
            3'h1: bsel_m = d[1:0];
            3'h2: if (bsel_m == 2'h0) sh_m.blk =
                (d > {6'h0, blk_max(sh_m.ctrl[2:1])}) ?
                blk_max(sh_m.ctrl[2:1]) : d[9:0];
            3'h3: rsel_m = d[1:0];
            3'h4: sh_m.rat[rsel_m] = (d > 16'h03FF) ? 10'h3FF : d[9:0];
            3'h5: if (d <= 16'h0004) sh_m.sh = d[2:0];
            default: ;
        endcase
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        logic [15:0] e;
        e = exp_reg(a);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        check("reg_rdata_out", e, reg_rdata_out);
    endtask : rd
    // ============================================================
    // pixel stream; settings written mid frame must wait for sof
    task automatic idle();
        @(posedge clk_sys_in);
        send <= 1'b0;
    endtask : idle
    task automatic frame(input int n);
        logic [11:0] d;
        logic [1:0]  c;
        for (int i = 0; i < n; i++) begin
            if (i == n / 2) begin
                idle();
                wr(3'h2, 16'($urandom_range(0, 1023)));
                wr(3'h4, 16'($urandom_range(0, 255)));
            end
            c = 2'($urandom_range(0, 3));
            d = 12'($urandom) >> $urandom_range(0, 4);
            @(posedge clk_sys_in);
            send <= 1'b1;
            beat <= '{valid: 1'b1, sof: (i == 0), eof: (i == n - 1),
                      colour: c, data: d};
        end
        idle();
        repeat (4) @(posedge clk_sys_in);
        check("beats left", 16'h0, 16'(exp_q.size()));
    endtask : frame
    // expectation taken when the design sees the beat
    always @(posedge clk_sys_in) begin
        if (rst_b_in && pix_in.valid) begin
            if (pix_in.sof) act_m = sh_m;
            exp_q.push_back({pix_in[15:12],
                             exp_pix(act_m, pix_in.colour, pix_in.data)});
        end
        if (rst_b_in && pix_out.valid) begin
            if (exp_q.size() == 0) check("extra beat", 16'h0, 16'h1);
            else check("pix_out", exp_q.pop_front(),
                       pix_out[15:0]);
        end
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 40000) begin
            $display("timeout after %0d cycles", cycles);
            miscompares++;
            results();
        end
    end
    // ============================================================
    // main sequence
    initial begin
        clk_sys_in   = 1'b0;
        rst_b_in     = 1'b0;
        reg_addr_in  = 3'h0;
        reg_wdata_in = 16'h0000;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        send         = 1'b0;
        beat         = '0;
        miscompares  = 0;
        n_compared   = 0;
        cycles       = 0;
        bsel_m       = 2'h0;
        rsel_m       = 2'h0;
        sh_m         = '{3'h0, 10'h000, 3'h0, {3{10'h040}}};
        act_m        = sh_m;
        void'($urandom(32'h5975eba9));
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a));
        $display("test reset values done, %0d compared", n_compared);
        wr(3'h0, 16'h0006);
        wr(3'h2, 16'h03FF);
        rd(3'h2);
        wr(3'h0, 16'h0000);
        rd(3'h2);
        wr(3'h5, 16'h0005);
        rd(3'h5);
        wr(3'h1, 16'h0001);
        wr(3'h2, 16'h0010);
        rd(3'h2);
        wr(3'h1, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            wr(3'h3, 16'(c));
            wr(3'h4, 16'h0010 + 16'(c));
        end
        for (int c = 0; c < 3; c++) begin
            wr(3'h3, 16'(c));
            rd(3'h4);
        end
        wr(3'h4, 16'hFFFF);
        rd(3'h4);
        wr(3'h7, 16'h1234);
        rd(3'h7);
        wr(3'h0, 16'h0002);
        rd(3'h2);
        $display("test registers done, %0d compared", n_compared);
        wr(3'h0, 16'h0001);
        wr(3'h2, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            wr(3'h3, 16'(c));
            wr(3'h4, 16'h0040);
        end
        frame(8);
        $display("test plain frame done, %0d compared", n_compared);
        // every variant with both depths, shift codes 0 to 5
        for (int f = 0; f < 24; f++) begin
            wr(3'h5, 16'h0000);
            wr(3'h0, {13'h0, 2'(f % 4), 1'(f / 4 % 2)});
            if (f % 4 != 1) wr(3'h5, 16'(f % 6));
            // every third frame keeps black at zero to reach unity checks
            wr(3'h2, (f % 3 == 1) ? 16'h0000
                                  : 16'($urandom_range(0, 1100)));
            for (int c = 0; c < 3; c++) begin
                wr(3'h3, 16'(c));
                wr(3'h4, 16'($urandom_range(0, 200)));
            end
            frame(10);
        end
        $display("test random frames done, %0d compared", n_compared);
        results();
    end
endmodule : testbench
`default_nettype wire
